// File: logic/dihs_pkg.sv
package dihs_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int START_TIME_US = 1000;
  localparam int TERM_TIME_US = 10000;
  localparam int START_CYC = START_TIME_US * CLK_MHZ;
  localparam int TERM_CYC = TERM_TIME_US * CLK_MHZ;
  localparam int IDLE_CYC_DEF = 1000;
  localparam int ECHO_CYC = 3; // Cycles an own drive echoes back through the synchronisers
  localparam int CNT_W = 24;
  // ****************************************
  // Channel indices
  // ****************************************
  localparam int CH_CLK = 0;
  localparam int CH_DAT = 1;
  // ****************************************
  // States
  // ****************************************
  typedef enum logic [2:0] {
    DIHS_INIT = 3'h0,
    DIHS_STARTUP = 3'h1,
    DIHS_TERM_WAIT = 3'h2,
    DIHS_TERM_TIME = 3'h3,
    DIHS_ARMED = 3'h4,
    DIHS_CONNECTED = 3'h5
  } dihs_state_t;
endpackage

// File: logic/dihs_bridge.sv
`timescale 1ns/10ps
module dihs_bridge #(
  parameter int START_CYCLES = dihs_pkg::START_CYC,
  parameter int TERM_CYCLES = dihs_pkg::TERM_CYC,
  parameter int IDLE_CYCLES = dihs_pkg::IDLE_CYC_DEF
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic enable_in,
  input wire logic supply_good_in,
  input wire logic refs_stable_in,
  input wire logic [1:0] card_line_in,
  output logic [1:0] card_line_out,
  output logic [1:0] card_line_oe_out,
  input wire logic [1:0] diff_plus_in,
  input wire logic [1:0] diff_minus_in,
  input wire logic [1:0] minus_below_hi_in,
  input wire logic [1:0] plus_above_lo_in,
  output logic [1:0] diff_plus_out,
  output logic [1:0] diff_plus_oe_out,
  output logic [1:0] diff_minus_out,
  output logic [1:0] diff_minus_oe_out,
  output logic connected_out
);
  // ****************************************
  // Parameter checks
  // ****************************************
  initial begin
    if (START_CYCLES < 1 || START_CYCLES >= (1 << dihs_pkg::CNT_W)) begin
      $error("START_CYCLES out of range");
    end
    if (TERM_CYCLES < 1 || TERM_CYCLES >= (1 << dihs_pkg::CNT_W)) begin
      $error("TERM_CYCLES out of range");
    end
    if (IDLE_CYCLES < 1 || IDLE_CYCLES >= (1 << dihs_pkg::CNT_W)) begin
      $error("IDLE_CYCLES out of range");
    end
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {enable_in, supply_good_in, refs_stable_in, card_line_in, diff_plus_in,
                diff_minus_in, minus_below_hi_in, plus_above_lo_in};
      sync2 <= sync1;
    end
  end
  logic en_s, pwr_s, ref_s;
  logic [1:0] card_s, dp_s, dm_s, mlo_s, phi_s;
  assign {en_s, pwr_s, ref_s, card_s, dp_s, dm_s, mlo_s, phi_s} = sync2;

  // Pair decode: plus above minus is released high
  function automatic logic pair_high(input logic p, input logic m);
    pair_high = p & ~m;
  endfunction

  logic [1:0] diff_high;
  for (genvar g = 0; g < 2; g++) begin : g_dec
    assign diff_high[g] = pair_high(dp_s[g], dm_s[g]);
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    dihs_pkg::dihs_state_t st;
    logic [dihs_pkg::CNT_W-1:0] cnt;
    logic [dihs_pkg::CNT_W-1:0] idle_cnt;
    logic [1:0] diff_prev;
    logic stop_seen;
    logic [1:0] drive_diff;
    logic [1:0] drive_card;
    logic [1:0][1:0] echo_hold;
  } dihs_regs_t;
  dihs_regs_t r, next_r;

  logic term_ok;
  assign term_ok = &mlo_s & &phi_s;

  // STOP and idle watch only run once armed and enabled
  logic watch_on;
  assign watch_on = (r.st == dihs_pkg::DIHS_ARMED) && en_s;

  // Sequence, bus watch and per-channel direction
  always_comb begin
    next_r = r;
    // STOP on line: data rises while clock is high
    if (!watch_on) begin
      next_r.stop_seen = 1'b0;
    end else if (diff_high[dihs_pkg::CH_CLK] && r.diff_prev[dihs_pkg::CH_CLK] &&
        diff_high[dihs_pkg::CH_DAT] && !r.diff_prev[dihs_pkg::CH_DAT]) begin
      next_r.stop_seen = 1'b1;
    end else if (!diff_high[dihs_pkg::CH_CLK] || !diff_high[dihs_pkg::CH_DAT]) begin
      next_r.stop_seen = 1'b0;
    end
    next_r.diff_prev = diff_high;
    if (watch_on && &dp_s) begin
      if (r.idle_cnt < dihs_pkg::CNT_W'(IDLE_CYCLES)) begin
        next_r.idle_cnt = r.idle_cnt + 1'b1;
      end
    end else begin
      next_r.idle_cnt = '0;
    end
    next_r.drive_diff = '0;
    next_r.drive_card = '0;
    case (r.st)
      dihs_pkg::DIHS_INIT: begin
        next_r.cnt = '0;
        next_r.echo_hold = '0;
        if (pwr_s && ref_s) begin
          next_r.st = dihs_pkg::DIHS_STARTUP;
        end
      end
      dihs_pkg::DIHS_STARTUP: begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == dihs_pkg::CNT_W'(START_CYCLES - 1)) begin
          next_r.st = dihs_pkg::DIHS_TERM_WAIT;
          next_r.cnt = '0;
        end
      end
      dihs_pkg::DIHS_TERM_WAIT: begin
        next_r.cnt = '0;
        if (term_ok) begin
          next_r.st = dihs_pkg::DIHS_TERM_TIME;
        end
      end
      dihs_pkg::DIHS_TERM_TIME: begin
        next_r.cnt = r.cnt + 1'b1;
        if (!term_ok) begin
          next_r.st = dihs_pkg::DIHS_TERM_WAIT;
        end else if (r.cnt == dihs_pkg::CNT_W'(TERM_CYCLES - 1)) begin
          next_r.st = dihs_pkg::DIHS_ARMED;
        end
      end
      dihs_pkg::DIHS_ARMED: begin
        if (en_s && ((r.idle_cnt == dihs_pkg::CNT_W'(IDLE_CYCLES)) ||
                     (&card_s && r.stop_seen))) begin
          next_r.st = dihs_pkg::DIHS_CONNECTED;
        end
      end
      dihs_pkg::DIHS_CONNECTED: begin
        for (int c = 0; c < 2; c++) begin
          // Receiver owns the channel while the line is low; own echo is ignored
          if (r.echo_hold[c] != 2'h0) begin
            next_r.echo_hold[c] = r.echo_hold[c] - 2'h1;
          end else if (!r.drive_diff[c] && !diff_high[c]) begin
            next_r.drive_card[c] = 1'b1;
          end else if (!r.drive_card[c] && !card_s[c]) begin
            next_r.drive_diff[c] = 1'b1;
          end
          // Release starts a hold so the stale echo cannot turn the channel around
          if ((r.drive_diff[c] || r.drive_card[c]) && !next_r.drive_diff[c] &&
              !next_r.drive_card[c]) begin
            next_r.echo_hold[c] = 2'(dihs_pkg::ECHO_CYC);
          end
        end
        if (!en_s || !term_ok) begin
          next_r.st = dihs_pkg::DIHS_INIT;
          next_r.drive_diff = '0;
          next_r.drive_card = '0;
        end
      end
      default: next_r.st = dihs_pkg::DIHS_INIT;
    endcase
    if (!pwr_s) begin
      next_r.st = dihs_pkg::DIHS_INIT;
      next_r.drive_diff = '0;
      next_r.drive_card = '0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Reversed polarity: plus pulled low, minus driven high
  assign card_line_out = '0;
  assign card_line_oe_out = r.drive_card;
  assign diff_plus_out = '0;
  assign diff_plus_oe_out = r.drive_diff;
  assign diff_minus_out = r.drive_diff;
  assign diff_minus_oe_out = r.drive_diff;
  assign connected_out = (r.st == dihs_pkg::DIHS_CONNECTED);

  // ****************************************
  // Assertions
  // ****************************************
  property p_en_low_no_connect;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      !en_s |=> !connected_out;
  endproperty
  a_en_low_no_connect: assert property (p_en_low_no_connect)
    else $error("connected while enable low");

  property p_connect_cause;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      $rose(connected_out) |-> $past(r.st) == dihs_pkg::DIHS_ARMED && $past(en_s);
  endproperty
  a_connect_cause: assert property (p_connect_cause)
    else $error("connect without armed and enable");

  property p_init_released;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      r.st == dihs_pkg::DIHS_INIT |-> card_line_oe_out == '0 && diff_plus_oe_out == '0
        && diff_minus_oe_out == '0;
  endproperty
  a_init_released: assert property (p_init_released)
    else $error("pin driven during init");

  property p_startup_len;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      $rose(r.st == dihs_pkg::DIHS_TERM_WAIT) && $past(r.st) == dihs_pkg::DIHS_STARTUP
        |-> $past(r.cnt) == dihs_pkg::CNT_W'(START_CYCLES - 1);
  endproperty
  a_startup_len: assert property (p_startup_len)
    else $error("startup timer wrong length");

  property p_term_start;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      r.st == dihs_pkg::DIHS_TERM_WAIT && term_ok && pwr_s |=>
        r.st == dihs_pkg::DIHS_TERM_TIME;
  endproperty
  a_term_start: assert property (p_term_start)
    else $error("termination timer not started");

  property p_armed_len;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      r.st == dihs_pkg::DIHS_ARMED && $past(r.st) == dihs_pkg::DIHS_TERM_TIME
        |-> $past(r.cnt) == dihs_pkg::CNT_W'(TERM_CYCLES - 1);
  endproperty
  a_armed_len: assert property (p_armed_len)
    else $error("termination timer wrong length");

  property p_power_loss;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      !pwr_s |=> r.st == dihs_pkg::DIHS_INIT;
  endproperty
  a_power_loss: assert property (p_power_loss)
    else $error("no restart after power loss");

  property p_one_role;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (r.drive_diff & r.drive_card) == 2'h0;
  endproperty
  a_one_role: assert property (p_one_role)
    else $error("channel drives both sides");

  property p_reverse_pulls;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      connected_out && en_s && term_ok && pwr_s && r.drive_diff == 2'h0 && !diff_high[0]
        && r.echo_hold[0] == 2'h0 |=> card_line_oe_out[0];
  endproperty
  a_reverse_pulls: assert property (p_reverse_pulls)
    else $error("reversed pair not passed to card");

  property p_echo_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      $fell(r.drive_card[0]) |=> !r.drive_diff[0];
  endproperty
  a_echo_hold: assert property (p_echo_hold)
    else $error("echo of own drive turned channel around");

  c_connect: cover property (@(posedge clk_sys_in) $rose(connected_out));
  c_drive_line: cover property (@(posedge clk_sys_in) |diff_plus_oe_out);
  c_drive_card: cover property (@(posedge clk_sys_in) |card_line_oe_out);
endmodule

// File: dv/dihs_far_model.sv
`timescale 1ns/10ps
// ****************************************
// Far side: line bias, termination, remote buffer
// ****************************************
module dihs_far_model (
  input wire logic clk_sys_in,
  input wire logic term_ok_in,
  input wire logic [1:0] remote_low_in,
  input wire logic [1:0] dut_plus_oe_in,
  input wire logic [1:0] dut_minus_oe_in,
  output logic [1:0] plus_out,
  output logic [1:0] minus_out,
  output logic [1:0] term_minus_out,
  output logic [1:0] term_plus_out
);
  logic [1:0] float_pat = 2'h1;
  // Changing levels on unterminated floating lines
  always @(posedge clk_sys_in) begin
    float_pat <= ~float_pat;
  end
  // Bias idles plus above minus; any driver reverses the pair
  always_comb begin
    if (term_ok_in) begin
      plus_out = ~(dut_plus_oe_in | remote_low_in);
      minus_out = dut_minus_oe_in | remote_low_in;
    end else begin
      plus_out = float_pat;
      minus_out = ~float_pat;
    end
    term_minus_out = {2{term_ok_in}};
    term_plus_out = {2{term_ok_in}};
  end
endmodule

// File: dv/tb_dihs_bridge.sv
`timescale 1ns/10ps
module tb_dihs_bridge;
  localparam int ST = 20;
  localparam int TM = 40;
  localparam int ID = 200;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic en = 1'b0;
  logic sup = 1'b0;
  logic refs = 1'b0;
  logic term = 1'b0;
  logic [1:0] card_low = 2'h0;
  logic [1:0] rem = 2'h0;
  logic [1:0] card_in, cl_out, cl_oe, dpi, dmi, mbh, pal, dpoe, dmoe;
  logic conn;
  logic [1:0] dpo, dmo;
  int n_mismatch = 0;
  int checked = 0;
  int n;
  // Clock and pulled-up card wires
  always #4 clk = ~clk;
  assign card_in = ~(cl_oe | card_low);
  dihs_bridge #(.START_CYCLES(ST), .TERM_CYCLES(TM), .IDLE_CYCLES(ID)) i_dihs_bridge (
    .clk_sys_in(clk), .rstn_in(rstn), .enable_in(en), .supply_good_in(sup),
    .refs_stable_in(refs), .card_line_in(card_in), .card_line_out(cl_out),
    .card_line_oe_out(cl_oe), .diff_plus_in(dpi), .diff_minus_in(dmi),
    .minus_below_hi_in(mbh), .plus_above_lo_in(pal), .diff_plus_out(dpo),
    .diff_plus_oe_out(dpoe), .diff_minus_out(dmo), .diff_minus_oe_out(dmoe),
    .connected_out(conn));
  dihs_far_model i_dihs_far_model (
    .clk_sys_in(clk), .term_ok_in(term), .remote_low_in(rem), .dut_plus_oe_in(dpoe),
    .dut_minus_oe_in(dmoe), .plus_out(dpi), .minus_out(dmi), .term_minus_out(mbh),
    .term_plus_out(pal));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_conn(input int lim);
    n = 0;
    while (conn !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_up();
    @(posedge clk);
    sup <= 1'b1;
    refs <= 1'b1;
    en <= 1'b1;
    cyc(ST + TM + 30);
    chk({1'b0, conn}, 2'h0, "connected without termination");
    @(posedge clk);
    term <= 1'b1;
    en <= 1'b0;
    cyc(TM + ID + 30);
    chk({1'b0, conn}, 2'h0, "connected while disabled");
    @(posedge clk);
    en <= 1'b1;
    wait_conn(ID + 10);
    chk({1'b0, conn}, 2'h1, "no connect on idle");
    chk(cl_out, 2'h0, "card value not low");
  endtask
  task automatic t_receive();
    @(posedge clk);
    rem <= 2'h2;
    cyc(6);
    chk(cl_oe, 2'h2, "data reversal not passed");
    chk(dpoe | dmoe, 2'h0, "drives pair while receiving");
    @(posedge clk);
    rem <= 2'h0;
    cyc(6);
    chk(cl_oe, 2'h0, "card not released");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      rem <= {1'b0, ~i[0]};
      cyc(6);
      chk(cl_oe, {1'b0, ~i[0]}, "link clock not followed");
      cyc(4);
    end
  endtask
  task automatic t_transmit();
    @(posedge clk);
    card_low <= 2'h1;
    cyc(6);
    chk(dpoe & dmoe, 2'h1, "pair not driven");
    chk(cl_oe, 2'h0, "card driven while sending");
    chk(dmo, 2'h1, "minus not driven high");
    chk(dpo, 2'h0, "plus not pulled low");
    @(posedge clk);
    card_low <= 2'h0;
    cyc(6);
    chk(dpoe | dmoe, 2'h0, "pair drivers not released");
  endtask
  task automatic t_drop_enable();
    @(posedge clk);
    en <= 1'b0;
    cyc(6);
    chk({1'b0, conn}, 2'h0, "still connected");
    @(posedge clk);
    rem <= 2'h2;
    cyc(6);
    chk(cl_oe | dpoe, 2'h0, "passes while disabled");
    @(posedge clk);
    rem <= 2'h0;
    en <= 1'b1;
    wait_conn(ST + TM + ID + 20);
    chk({1'b0, conn}, 2'h1, "no reconnect");
    chk({1'b0, n >= ST + TM}, 2'h1, "reconnect without rerun");
  endtask
  task automatic t_stop();
    @(posedge clk);
    rem <= 2'h2;
    sup <= 1'b0;
    cyc(4);
    chk({1'b0, conn}, 2'h0, "connected without power");
    @(posedge clk);
    sup <= 1'b1;
    cyc(ST + TM + 20);
    chk({1'b0, conn}, 2'h0, "connected on busy line");
    @(posedge clk);
    rem <= 2'h0;
    wait_conn(8);
    chk({1'b0, conn}, 2'h1, "no connect after stop");
  endtask
  // Main sequence
  initial begin
    cyc(5);
    chk(cl_oe | dpoe | dmoe, 2'h0, "pins driven in reset");
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_power_up();
    t_receive();
    t_transmit();
    t_drop_enable();
    t_stop();
    report_and_stop();
  end
  // Watchdog
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
